// ===== common/cgl_pkg.sv
// Package of constants and types for the clock output gating and loss block.
package cgl_pkg;

  // ----------------------------------------------------------------
  // Sizes and clock rate
  // ----------------------------------------------------------------
  localparam int N_OUT = 8;        // Gated clock outputs.
  localparam int N_IN = 2;         // Reference input clocks.
  localparam int ADDR_W = 8;       // APB byte address width.
  localparam int CNT_W = 16;       // Idle counter width.
  localparam int EDGE_W = 4;       // Valid edge counter width.
  localparam int CLK_MHZ = 100;    // System clock rate.

  // ----------------------------------------------------------------
  // Times
  // ----------------------------------------------------------------
  localparam int LOS_TIME_NS = 200;  // Silence that counts as loss.
  localparam int LOS_CYC = (LOS_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int VALID_EDGES = 4;    // Rising edges that prove a clock.

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_OUT_EN = 6'h10;  // Per-output enable bits.
  localparam logic [5:0] IDX_CTRL = 6'h11;    // Input select and parking.
  localparam logic [5:0] IDX_IN_CFG = 6'h23;  // Input bias and termination.
  localparam logic [5:0] IDX_EVT = 6'h27;     // Sticky loss events.
  localparam logic [5:0] IDX_EVT_MASK = 6'h28; // Interrupt mask.
  localparam logic [5:0] IDX_STATE = 6'h29;   // Live state.

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_SEL_BIT = 0;
  localparam int CTRL_PARK_BIT = 1;
  localparam int EVT_LSB = 1;           // Input 0 event at bit 1, input 1 at bit 2.
  localparam int ST_LOS_BIT = 0;
  localparam int ST_GATE_LSB = 8;
  localparam logic OUT_EN_RST = 1'b1;
  localparam logic PARK_RST = 1'b1;
  localparam logic LOS_RST = 1'b1;
  localparam int IN_CFG_W = 4; // Two configuration bits per input.
  localparam int CFG_TERM0_BIT = 0; // Receiver termination of input 0.
  localparam int CFG_BIAS0_BIT = 1; // Coupling bias of input 0.
  localparam int CFG_TERM1_BIT = 2; // Receiver termination of input 1.
  localparam int CFG_BIAS1_BIT = 3; // Coupling bias of input 1.
  localparam logic [IN_CFG_W-1:0] IN_CFG_RST = 4'h0;

  // Whole state of the block, registered in one place.
  typedef struct packed {
    logic [31:0] rdata;
    logic err;
    logic [N_OUT-1:0] out_en;
    logic sel;
    logic park;
    logic [IN_CFG_W-1:0] in_cfg;
    logic [N_IN-1:0] evt;
    logic [N_IN-1:0] mask;
    logic [N_IN-1:0] ref_s1;
    logic [N_IN-1:0] ref_s2;
    logic ref_prev;
    logic [N_OUT-1:0] oen_s1;
    logic [N_OUT-1:0] oen_s2;
    logic [CNT_W-1:0] idle_cnt;
    logic [EDGE_W-1:0] edge_cnt;
    logic los;
    logic [N_OUT-1:0] gate;
    logic [N_OUT-1:0] out_t;
    logic [N_OUT-1:0] out_c;
  } cgl_state_t;

  // APB request grouped as it travels.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } cgl_apb_req_t;

endpackage : cgl_pkg

// ===== rtl/cgl_top.sv
// Clock output gating, loss detection and parking with an APB register file.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module cgl_top import cgl_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // APB slave.
  input wire cgl_apb_req_t apb_req,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Reference clocks and enable pins, asynchronous to clk.
  input wire logic [N_IN-1:0] reference_input_clock,
  input wire logic [N_OUT-1:0] output_enable_n_pin,
  // Enable from the side-band logic of the unit, on clk.
  input wire logic [N_OUT-1:0] sideband_en,
  // Gated clock outputs, true and complement.
  output logic [N_OUT-1:0] clk_out_t,
  output logic [N_OUT-1:0] clk_out_c,
  // Open-drain loss indicator and input configuration.
  output logic loss_indicator_n_pin_o,
  output logic loss_indicator_n_pin_oe,
  output logic [N_IN-1:0] ac_coupled_bias_enable,
  output logic [N_IN-1:0] rx_term_enable,
  // Interrupt.
  output logic irq
);

  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------
  cgl_state_t st_q;  // Registered state.
  cgl_state_t st_d;  // Next state.
  logic [5:0] idx;   // Word index of the access.
  logic setup;       // Setup phase of a transfer.
  logic wr_go;       // Write taking effect this edge.
  logic cur_clk;     // Synchronised sample of the selected input.
  logic edge_seen;   // Any change on the selected input.
  logic rise_seen;   // Rising change on the selected input.
  logic [N_OUT-1:0] en_all;  // All enables combined.

  assign idx = apb_req.paddr[ADDR_W-1:2];
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_go = apb_req.psel && apb_req.penable && apb_req.pwrite && !st_q.err;

  // Zero wait states: data and error were latched in setup.
  assign pready = apb_req.psel && apb_req.penable;
  assign pslverr = pready && st_q.err;
  assign prdata = st_q.rdata;

  assign cur_clk = st_q.ref_s2[st_q.sel];
  assign edge_seen = cur_clk != st_q.ref_prev;
  assign rise_seen = cur_clk && !st_q.ref_prev;

  assign en_all = st_q.out_en & ~st_q.oen_s2 & sideband_en;

  // Read value for an index; unmapped indices are flagged separately.
  function automatic logic [31:0] read_mux(input cgl_state_t s, input logic [5:0] i);
    logic [31:0] v;
    v = '0;
    case (i)
      IDX_OUT_EN: v[N_OUT-1:0] = s.out_en;
      IDX_CTRL: begin
        v[CTRL_SEL_BIT] = s.sel;
        v[CTRL_PARK_BIT] = s.park;
      end
      IDX_IN_CFG: v[IN_CFG_W-1:0] = s.in_cfg;
      IDX_EVT: v[EVT_LSB +: N_IN] = s.evt;
      IDX_EVT_MASK: v[EVT_LSB +: N_IN] = s.mask;
      IDX_STATE: begin
        v[ST_LOS_BIT] = s.los;
        v[ST_GATE_LSB +: N_OUT] = s.gate;
      end
      default: v = '0;
    endcase
    return v;
  endfunction : read_mux

  // Recognised register indices.
  function automatic logic mapped(input logic [5:0] i);
    return (i == IDX_OUT_EN) || (i == IDX_CTRL) || (i == IDX_IN_CFG) ||
           (i == IDX_EVT) || (i == IDX_EVT_MASK) || (i == IDX_STATE);
  endfunction : mapped

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // All state is computed here and registered below.
  always_comb begin
    st_d = st_q;

    // Two-flop synchronisers for the pins.
    st_d.ref_s1 = reference_input_clock;
    st_d.ref_s2 = st_q.ref_s1;
    st_d.oen_s1 = output_enable_n_pin;
    st_d.oen_s2 = st_q.oen_s1;
    st_d.ref_prev = cur_clk;

    // Setup phase latches read data and the error answer.
    if (setup) begin
      st_d.err = !mapped(idx) || (apb_req.paddr[1:0] != 2'b00);
      st_d.rdata = read_mux(st_q, idx);
    end

    // Register writes.
    if (wr_go) begin
      case (idx)
        IDX_OUT_EN: st_d.out_en = apb_req.pwdata[N_OUT-1:0];
        IDX_CTRL: begin
          st_d.sel = apb_req.pwdata[CTRL_SEL_BIT];
          st_d.park = apb_req.pwdata[CTRL_PARK_BIT];
        end
        IDX_IN_CFG: st_d.in_cfg = apb_req.pwdata[IN_CFG_W-1:0];
        IDX_EVT_MASK: st_d.mask = apb_req.pwdata[EVT_LSB +: N_IN];
        default: st_d.mask = st_q.mask;
      endcase
    end

    if (wr_go && idx == IDX_EVT) begin
      st_d.evt = st_q.evt & ~apb_req.pwdata[EVT_LSB +: N_IN];
    end

    // Loss detector: count silence, then count edges back to valid.
    // idle counter saturates, no timeout
    if (edge_seen) begin
      st_d.idle_cnt = '0;
    end else if (st_q.idle_cnt != CNT_W'(LOS_CYC)) begin
      st_d.idle_cnt = st_q.idle_cnt + 1'b1;
    end
    if (!edge_seen && st_q.idle_cnt == CNT_W'(LOS_CYC - 1)) begin
      st_d.los = 1'b1;
      st_d.edge_cnt = '0;
    end else if (st_q.los && rise_seen) begin
      if (st_q.edge_cnt == EDGE_W'(VALID_EDGES - 1)) begin
        st_d.los = 1'b0;
        st_d.edge_cnt = '0;
      end else begin
        st_d.edge_cnt = st_q.edge_cnt + 1'b1;
      end
    end
    // A change of selection starts proof afresh, since the new input is unknown.
    if (wr_go && idx == IDX_CTRL && apb_req.pwdata[CTRL_SEL_BIT] != st_q.sel) begin
      st_d.los = 1'b1;
      st_d.edge_cnt = '0;
      st_d.idle_cnt = '0;
    end

    // flag of the selected input
    // A new loss wins over a clear in the same cycle.
    if (!st_q.los && st_d.los) begin
      st_d.evt[st_q.sel] = 1'b1;
    end

    // Gate update: the combined enable is taken only while the clock is low.
    // switch only while low
    for (int i = 0; i < N_OUT; i++) begin
      if (!cur_clk) begin
        st_d.gate[i] = en_all[i];
      end
    end
    // parking after loss
    // A stopped clock has no low phase to wait for, so parking acts at once.
    if (st_q.los && st_q.park) begin
      st_d.gate = '0;
    end

    // Outputs follow the sampled clock through the gate.
    // disabled output low/low
    st_d.out_t = {N_OUT{cur_clk}} & st_q.gate;
    st_d.out_c = {N_OUT{!cur_clk}} & st_q.gate;
    if (st_q.los && st_q.park) begin
      st_d.out_t = '0;
      st_d.out_c = '0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset puts every field at its defined value.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.out_en <= {N_OUT{OUT_EN_RST}};
      st_q.park <= PARK_RST;
      st_q.in_cfg <= IN_CFG_RST;
      st_q.los <= LOS_RST;
      st_q.oen_s1 <= '1;
      st_q.oen_s2 <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign clk_out_t = st_q.out_t;
  assign clk_out_c = st_q.out_c;
  // open drain, pulled low on loss
  assign loss_indicator_n_pin_o = 1'b0;
  assign loss_indicator_n_pin_oe = st_q.los;
  assign rx_term_enable = {st_q.in_cfg[CFG_TERM1_BIT], st_q.in_cfg[CFG_TERM0_BIT]};
  assign ac_coupled_bias_enable = {st_q.in_cfg[CFG_BIAS1_BIT], st_q.in_cfg[CFG_BIAS0_BIT]};
  // Level interrupt while an unmasked event stands.
  assign irq = |(st_q.evt & st_q.mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_los_on_silence:
    assert property (!edge_seen && st_q.idle_cnt == CNT_W'(LOS_CYC - 1) |=> st_q.los)
    else $error("loss not flagged after silence");

  a_event_on_loss:
    assert property (!st_q.los && st_d.los |=> st_q.evt[$past(st_q.sel)] && loss_indicator_n_pin_oe)
    else $error("loss did not set its event");

  a_los_after_reset:
    assert property ($fell(rst) |-> st_q.los && loss_indicator_n_pin_oe && &st_q.out_en)
    else $error("reset values of loss or enables wrong");

  a_park_low:
    assert property (st_q.los && st_q.park |=> clk_out_t == '0 && clk_out_c == '0)
    else $error("outputs not parked after loss");

  a_gate_and:
    assert property (((clk_out_t | clk_out_c) & ~$past(st_q.gate)) == '0)
    else $error("output ran while gate closed");

  a_gate_when_low:
    assert property (st_d.gate != st_q.gate && !(st_q.los && st_q.park) |-> !cur_clk)
    else $error("gate changed while clock high");

  a_w1c_only:
    assert property (|(st_q.evt & ~st_d.evt) |-> wr_go && idx == IDX_EVT)
    else $error("event cleared without a write");

  a_valid_edges:
    assert property ($fell(st_q.los) |-> $past(st_q.edge_cnt) == EDGE_W'(VALID_EDGES - 1))
    else $error("loss released too early");

  a_true_comp:
    assert property (!(|(clk_out_t & clk_out_c)) ##1 !(|(clk_out_t & clk_out_c)))
    else $error("true and complement both high");

  a_bit_disables:
    assert property (!cur_clk |=> (st_q.gate & ~$past(st_q.out_en)) == '0)
    else $error("gate open for a disabled output bit");

  a_pin_disables:
    assert property (!cur_clk |=> (st_q.gate & $past(st_q.oen_s2)) == '0)
    else $error("gate open for an output whose pin is high");

endmodule : cgl_top

// ===== testbench/cgl_ctl_model.sv
// Model of the system controller: reference clocks, enable pins, loss pull-up.
`timescale 1ns/1ps
module cgl_ctl_model import cgl_pkg::*; (
  // Commands from the bench.
  input wire logic [N_IN-1:0] run,
  input wire logic [N_OUT-1:0] pin_off,
  // Open-drain loss pin of the device.
  input wire logic los_o,
  input wire logic los_oe,
  // Lines towards the device and the board.
  output logic [N_IN-1:0] ref_clk,
  output logic [N_OUT-1:0] oe_n_pin,
  output logic los_wire
);
  // clock kept running
  // A 10 MHz input stays well under a quarter of the system clock.
  // A stopped input rests low, so the device sees plain silence.
  initial ref_clk = '0;
  always #50 ref_clk = run & ~ref_clk;

  // pin level
  // An output is switched off by driving its pin high.
  assign oe_n_pin = pin_off;

  // pulled up line
  // The board pull-up wins unless the device pulls the line low.
  assign los_wire = los_oe ? los_o : 1'b1;
endmodule : cgl_ctl_model

// ===== testbench/testbench.sv
// Self-checking bench for the clock output gating and loss block.
`timescale 1ns/1ps
module testbench import cgl_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  cgl_apb_req_t req = '0;
  logic pready, pslverr, irq, los_o, los_oe, los_wire, err;
  logic [31:0] prdata, rd;
  logic [N_IN-1:0] run = '0, ref_clk, ac_en, term_en;
  logic [N_OUT-1:0] pin_off = '0, side_en = '1, oe_n, out_t, out_c, seen;
  int n_errors = 0;
  int checks = 0;
  // Byte addresses are four times the register index.
  localparam logic [7:0] A_OEN = {IDX_OUT_EN, 2'b00};
  localparam logic [7:0] A_CTL = {IDX_CTRL, 2'b00};
  localparam logic [7:0] A_CFG = {IDX_IN_CFG, 2'b00};
  localparam logic [7:0] A_EVT = {IDX_EVT, 2'b00};
  localparam logic [7:0] A_MSK = {IDX_EVT_MASK, 2'b00};
  localparam logic [7:0] A_ST = {IDX_STATE, 2'b00};

  always #5 clk = ~clk;

  cgl_top cgl_top_inst (.clk(clk), .rst(rst), .apb_req(req), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .reference_input_clock(ref_clk),
    .output_enable_n_pin(oe_n), .sideband_en(side_en), .clk_out_t(out_t),
    .clk_out_c(out_c), .loss_indicator_n_pin_o(los_o), .loss_indicator_n_pin_oe(los_oe),
    .ac_coupled_bias_enable(ac_en), .rx_term_enable(term_en), .irq(irq));

  cgl_ctl_model cgl_ctl_model_inst (.run(run), .pin_off(pin_off), .los_o(los_o),
    .los_oe(los_oe), .ref_clk(ref_clk), .oe_n_pin(oe_n), .los_wire(los_wire));

  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= addr;
    req.pwdata <= wd;
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) begin
      n_errors++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // Reads one register and compares it.
  task automatic rdc(input string what, input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk(what, exp, rd);
  endtask : rdc

  // Collects which outputs were seen high during n cycles.
  task automatic watch(input int n);
    seen = '0;
    repeat (n) begin
      @(negedge clk);
      seen = seen | out_t | out_c;
    end
    @(posedge clk);
  endtask : watch

  // Checks the loss line and the interrupt at a settled point.
  task automatic pins(input logic exp_los, input logic exp_irq);
    @(negedge clk);
    chk("loss line", 32'(exp_los), 32'(los_wire));
    chk("irq", 32'(exp_irq), 32'(irq));
    @(posedge clk);
  endtask : pins

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  // Main sequence.
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    pins(1'b0, 1'b0);
    rdc("out_en", A_OEN, 32'h0000_00ff);
    rdc("ctrl", A_CTL, 32'h0000_0002);
    rdc("in_cfg", A_CFG, 32'h0);
    repeat (200) @(posedge clk);
    pins(1'b0, 1'b0);
    rdc("events", A_EVT, 32'h0);
    $display("test reset done");
    run <= 2'b01;
    repeat (80) @(posedge clk);
    pins(1'b1, 1'b0);
    rdc("state", A_ST, 32'h0000_ff00);
    watch(40);
    chk("all outputs", 32'h0000_00ff, 32'(seen));
    apb(1'b1, A_OEN, 32'h0000_00fe);
    pin_off <= 8'h02;
    side_en <= 8'hfb;
    repeat (30) @(posedge clk);
    watch(40);
    chk("gated outputs", 32'h0000_00f8, 32'(seen));
    apb(1'b1, A_OEN, 32'h0000_00ff);
    pin_off <= 8'h00;
    side_en <= 8'hff;
    repeat (30) @(posedge clk);
    watch(40);
    chk("restarted outputs", 32'h0000_00ff, 32'(seen));
    $display("test gating done");
    apb(1'b1, A_CFG, 32'h0000_0006);
    rdc("in_cfg", A_CFG, 32'h0000_0006);
    chk("bias and term", 32'h0000_0006, 32'({ac_en, term_en}));
    apb(1'b0, 8'h00, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, A_OEN + 8'h01, 32'h0);
    chk("unaligned error", 32'h1, 32'(err));
    rdc("out_en kept", A_OEN, 32'h0000_00ff);
    $display("test config done");
    apb(1'b1, A_MSK, 32'h0000_0002);
    run <= 2'b00;
    repeat (40) @(posedge clk);
    pins(1'b0, 1'b1);
    rdc("events", A_EVT, 32'h0000_0002);
    watch(20);
    chk("parked outputs", 32'h0, 32'(seen));
    run <= 2'b01;
    repeat (80) @(posedge clk);
    pins(1'b1, 1'b1);
    apb(1'b1, A_EVT, 32'h0000_0002);
    pins(1'b1, 1'b0);
    $display("test loss done");
    run <= 2'b11;
    apb(1'b1, A_CTL, 32'h0000_0003);
    repeat (80) @(posedge clk);
    apb(1'b1, A_EVT, 32'h0000_0006);
    pins(1'b1, 1'b0);
    run <= 2'b01;
    repeat (40) @(posedge clk);
    pins(1'b0, 1'b0);
    rdc("events", A_EVT, 32'h0000_0004);
    $display("test select done");
    apb(1'b1, A_CTL, 32'h0000_0000);
    repeat (80) @(posedge clk);
    pins(1'b1, 1'b0);
    run <= 2'b00;
    repeat (40) @(posedge clk);
    pins(1'b0, 1'b1);
    watch(20);
    chk("unparked outputs", 32'h0000_00ff, 32'(seen));
    rdc("events", A_EVT, 32'h0000_0006);
    $display("test park off done");
    close_out();
  end

  // Watchdog: the sequence needs about 1000 cycles.
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
endmodule : testbench
